//--- pkg/adc_readout_pkg.sv
/*
 * Shared constants and types of the converter serial readout block.
 * Assumes a 50 MHz core clock; the serial clock is supplied by the host.
 */
package adc_readout_pkg;

    // ****************************************************************
    // data path
    // ****************************************************************
    localparam int WORD_W     = 16;
    localparam int MSB        = WORD_W - 1;
    localparam int FIFO_DEPTH = 32;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CORE_CLK_NS  = 20;
    // longest conversion; the core waits this long before readout
    localparam int CONV_TIME_NS = 1300;
    localparam int CONV_CYC     = (CONV_TIME_NS / CORE_CLK_NS < 1) ? 1 :
                                  CONV_TIME_NS / CORE_CLK_NS;
    localparam int CONV_CNT_W   = 7;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYC - 1);

    // host-side pulse limits, kept for reference only; the bench does not use them
    localparam int CNV_HIGH_MIN_NS = 10;
    localparam int DIN_HIGH_MIN_NS = 10;
    localparam int CNV_LOW_MIN_NS  = 20;
    localparam int MODE_SETUP_PS   = 7500;
    localparam int CLK_SETUP_NS    = 5;

    // ****************************************************************
    // serial side
    // ****************************************************************
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] BITS_LAST = BIT_CNT_W'(WORD_W);
    localparam logic [BIT_CNT_W-1:0] BIT_ONE   = 5'h01;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_CONV  = 6'h02,
        ST_WAIT  = 6'h04,
        ST_READ3 = 6'h08,
        ST_READ4 = 6'h10,
        ST_DAISY = 6'h20
    } rd_state_t;

endpackage : adc_readout_pkg

//--- pkg/fifo_if.sv
/*
 * Valid/ready carrier between the readout core and its sample FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 16);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport store (input wr_valid, wr_data, rd_ready,
                   output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data);
endinterface : fifo_if

//--- src/adc_serial_readout.sv
/*
 * Conversion start and serial readout of a single-channel converter:
 * three-wire, four-wire and daisy-chain arrangements.
 * Assumes the analog core pushes results into sample_data_i, the host
 * keeps the serial clock still while no readout is armed, and pins
 * conversion_start_line_i and serial_in_i are asynchronous to core_clk_i.
 */
`timescale 1ns/1ps
// How it works
// - three-wire: start line low enables output with the MSB
// - output advances one bit after each serial clock falling edge
// - three-wire: output released on start high or last falling edge
// - four-wire: serial input low enables output with the MSB
// - four-wire: output released on input high or last falling edge
// - daisy: serial input captured on serial clock falling edges
// - chip-select or daisy arrangement chosen from serial input level at conversion start
module adc_serial_readout (
    input  wire logic        core_clk_i,              // core clock
    input  wire logic        rst_b_i,                 // reset, active low
    input  wire logic        serial_clk_i,            // host serial clock
    input  wire logic        conversion_start_line_i, // start / cs pin
    input  wire logic        serial_in_i,             // serial in / cs pin
    output logic             serial_out_o,            // serial data out
    output logic             serial_out_oe_o,         // serial out drive
    input  wire logic [15:0] sample_data_i,           // result from core
    input  wire logic        sample_valid_i,          // result valid
    output logic             sample_ready_o,          // fifo has room
    output logic             conv_start_o             // start pulse
);

    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic       cnv_meta_q, cnv_s_q, cnv_prev_q;
    logic       din_meta_q, din_s_q;
    logic       conv_rise;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnv_meta_q <= 1'b1;
            cnv_s_q    <= 1'b1;
            cnv_prev_q <= 1'b1;
            din_meta_q <= 1'b0;
            din_s_q    <= 1'b0;
        end else begin
            cnv_meta_q <= conversion_start_line_i;
            cnv_s_q    <= cnv_meta_q;
            cnv_prev_q <= cnv_s_q;
            din_meta_q <= serial_in_i;
            din_s_q    <= din_meta_q;
        end
    end
    // pulses shorter than one core clock may be missed
    assign conv_rise = cnv_s_q && !cnv_prev_q;

    // ****************************************************************
    // sample buffer
    // ****************************************************************
    fifo_if #(.WIDTH(adc_readout_pkg::WORD_W)) smp_if ();
    logic pop;

    assign smp_if.wr_valid = sample_valid_i;
    assign smp_if.wr_data  = sample_data_i;
    assign smp_if.rd_ready = pop;
    assign sample_ready_o  = smp_if.wr_ready;

    sample_fifo #(
        .WIDTH (adc_readout_pkg::WORD_W),
        .DEPTH (adc_readout_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .port_io (smp_if.store)
    );

    // ****************************************************************
    // conversion and arrangement control
    // ****************************************************************
    adc_readout_pkg::rd_state_t state_q, state_d;
    logic [adc_readout_pkg::CONV_CNT_W-1:0] timer_q, timer_d;
    logic [adc_readout_pkg::WORD_W-1:0]     word_q, word_d;
    logic cs_mode_q, cs_mode_d;
    logic start_q, start_d;
    logic run_q, run_d;

    always_comb begin
        state_d   = state_q;
        timer_d   = timer_q;
        word_d    = word_q;
        cs_mode_d = cs_mode_q;
        start_d   = 1'b0;
        pop       = 1'b0;
        if (conv_rise) begin
            // rising start line ends any readout and starts a conversion
            state_d   = adc_readout_pkg::ST_CONV;
            timer_d   = '0;
            cs_mode_d = din_s_q;
            start_d   = 1'b1;
        end else begin
            unique case (state_q)
                adc_readout_pkg::ST_IDLE: begin
                end
                adc_readout_pkg::ST_CONV: begin
                    if (timer_q != adc_readout_pkg::CONV_LAST) begin
                        timer_d = timer_q + 1'b1;
                    end else if (smp_if.rd_valid) begin
                        word_d  = smp_if.rd_data;
                        pop     = 1'b1;
                        state_d = adc_readout_pkg::ST_WAIT;
                    end
                end
                adc_readout_pkg::ST_WAIT: begin
                    if (!cs_mode_q) begin
                        if (!cnv_s_q) begin
                            state_d = adc_readout_pkg::ST_DAISY;
                        end
                    end else if (!cnv_s_q) begin
                        state_d = adc_readout_pkg::ST_READ3;
                    end else if (!din_s_q) begin
                        state_d = adc_readout_pkg::ST_READ4;
                    end
                end
                adc_readout_pkg::ST_READ3: begin
                end
                adc_readout_pkg::ST_READ4: begin
                    if (din_s_q) begin
                        state_d = adc_readout_pkg::ST_IDLE;
                    end
                end
                adc_readout_pkg::ST_DAISY: begin
                end
            endcase
        end
        run_d = (state_d == adc_readout_pkg::ST_READ3) ||
                (state_d == adc_readout_pkg::ST_READ4) ||
                (state_d == adc_readout_pkg::ST_DAISY);
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= adc_readout_pkg::ST_IDLE;
            timer_q   <= '0;
            word_q    <= '0;
            cs_mode_q <= 1'b0;
            start_q   <= 1'b0;
            run_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            timer_q   <= timer_d;
            word_q    <= word_d;
            cs_mode_q <= cs_mode_d;
            start_q   <= start_d;
            run_q     <= run_d;
        end
    end
    assign conv_start_o = start_q;

    // ****************************************************************
    // serial clock domain
    // ****************************************************************
    // held clear while no readout is armed; word_q and cs_mode_q stay
    // still throughout a readout, so the link reads them directly
    logic link_rst_n;
    logic [adc_readout_pkg::BIT_CNT_W-1:0] idx_q, idx_d;
    logic [adc_readout_pkg::WORD_W-1:0]    shreg_q, shreg_d;
    logic                                  cs_done;

    assign link_rst_n = rst_n && run_q;

    always_comb begin
        idx_d = (idx_q != adc_readout_pkg::BITS_LAST) ?
                idx_q + adc_readout_pkg::BIT_ONE : idx_q;
        // first edge loads the word, later edges shift; din enters lsb
        if (idx_q == '0) begin
            shreg_d = {word_q[adc_readout_pkg::MSB-1:0], serial_in_i};
        end else begin
            shreg_d = {shreg_q[adc_readout_pkg::MSB-1:0], serial_in_i};
        end
    end

    always_ff @(negedge serial_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            idx_q   <= '0;
            shreg_q <= '0;
        end else begin
            idx_q   <= idx_d;
            shreg_q <= shreg_d;
        end
    end

    // daisy keeps shifting the upstream data; cs modes stop after the lsb
    assign cs_done = cs_mode_q && (idx_q == adc_readout_pkg::BITS_LAST);
    assign serial_out_oe_o = run_q && !cs_done;
    assign serial_out_o = (idx_q == '0) ? word_q[adc_readout_pkg::MSB] :
                          shreg_q[adc_readout_pkg::MSB];

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_msb_three_wire;
        @(posedge core_clk_i) disable iff (!rst_n)
        (state_q == adc_readout_pkg::ST_READ3 && idx_q == '0) |->
        (serial_out_oe_o && serial_out_o == word_q[adc_readout_pkg::MSB]);
    endproperty
    a_msb_three_wire: assert property (p_msb_three_wire)
        else $error("three-wire readout did not present the msb");

    property p_msb_four_wire;
        @(posedge core_clk_i) disable iff (!rst_n)
        (state_q == adc_readout_pkg::ST_READ4 && idx_q == '0) |->
        (serial_out_oe_o && serial_out_o == word_q[adc_readout_pkg::MSB]);
    endproperty
    a_msb_four_wire: assert property (p_msb_four_wire)
        else $error("four-wire readout did not present the msb");

    property p_end_three_wire;
        @(posedge core_clk_i) disable iff (!rst_n)
        (state_q == adc_readout_pkg::ST_READ3 && conv_rise) |=>
        !serial_out_oe_o;
    endproperty
    a_end_three_wire: assert property (p_end_three_wire)
        else $error("output still driven after start line rose");

    property p_end_four_wire;
        @(posedge core_clk_i) disable iff (!rst_n)
        (state_q == adc_readout_pkg::ST_READ4 && din_s_q && !conv_rise)
        |=> !serial_out_oe_o ##1 !serial_out_oe_o;
    endproperty
    a_end_four_wire: assert property (p_end_four_wire)
        else $error("output still driven after serial input rose");

    property p_mode_cs;
        @(posedge core_clk_i) disable iff (!rst_n)
        (conv_rise && din_s_q) |=>
        (cs_mode_q && conv_start_o && state_q == adc_readout_pkg::ST_CONV);
    endproperty
    a_mode_cs: assert property (p_mode_cs)
        else $error("chip select mode not taken at conversion start");

    property p_mode_daisy;
        @(posedge core_clk_i) disable iff (!rst_n)
        (conv_rise && !din_s_q) |=>
        (!cs_mode_q && state_q == adc_readout_pkg::ST_CONV);
    endproperty
    a_mode_daisy: assert property (p_mode_daisy)
        else $error("daisy mode not taken at conversion start");

    property p_shift;
        @(negedge serial_clk_i) disable iff (!link_rst_n)
        (idx_q == '0) |=>
        (serial_out_o == $past(word_q[adc_readout_pkg::MSB-1])) ##1
        (serial_out_o == $past(word_q[adc_readout_pkg::MSB-2], 2));
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial output did not advance on falling edge");

    property p_last_edge;
        @(posedge core_clk_i) disable iff (!rst_n)
        (cs_mode_q && idx_q == adc_readout_pkg::BITS_LAST) |->
        !serial_out_oe_o;
    endproperty
    a_last_edge: assert property (p_last_edge)
        else $error("output still driven after last falling edge");

    property p_daisy_capture;
        @(negedge serial_clk_i) disable iff (!link_rst_n)
        (!cs_mode_q && idx_q == adc_readout_pkg::BITS_LAST) |->
        (serial_out_o == $past(serial_in_i, 16));
    endproperty
    a_daisy_capture: assert property (p_daisy_capture)
        else $error("daisy input not passed through sixteen edges");

endmodule : adc_serial_readout

//--- src/sample_fifo.sv
/*
 * Sample FIFO with a registered read port.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic clk_i,   // core clock
    input  wire logic rst_n_i, // synchronised reset, active low
    fifo_if.store     port_io  // write and read sides
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
    logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             out_valid_q, out_valid_d;
    logic [WIDTH-1:0] out_data_q, out_data_d;
    logic             push;
    logic             fetch;

    // ****************************************************************
    // pointers and output register
    // ****************************************************************
    always_comb begin
        push        = port_io.wr_valid && (cnt_q != FULL_CNT);
        fetch       = (cnt_q != '0) && (!out_valid_q || port_io.rd_ready);
        wr_ptr_d    = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d    = fetch ? rd_ptr_q + 1'b1 : rd_ptr_q;
        out_data_d  = fetch ? mem_q[rd_ptr_q] : out_data_q;
        out_valid_d = fetch ? 1'b1 :
                      (port_io.rd_ready ? 1'b0 : out_valid_q);
        unique case ({push, fetch})
            2'b10:   cnt_d = cnt_q + 1'b1;
            2'b01:   cnt_d = cnt_q - 1'b1;
            default: cnt_d = cnt_q;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            wr_ptr_q    <= wr_ptr_d;
            rd_ptr_q    <= rd_ptr_d;
            cnt_q       <= cnt_d;
            out_valid_q <= out_valid_d;
            out_data_q  <= out_data_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= port_io.wr_data;
        end
    end

    assign port_io.wr_ready = (cnt_q != FULL_CNT);
    assign port_io.rd_valid = out_valid_q;
    assign port_io.rd_data  = out_data_q;

endmodule : sample_fifo

//--- testbench/host_model.sv
/*
 * Host model: drives the start line, serial clock and serial input, and
 * samples the serial output. Assumes the bench calls its tasks one at a
 * time; the serial clock (32 ns) idles high between frames.
 */
`timescale 1ns/1ps
module host_model (
    input  wire logic  core_clk_i, // core clock, pacing only
    input  wire logic  sdo_i,      // serial data from the converter
    input  wire logic  sdo_oe_i,   // converter drives the pin
    output logic       sclk_o,     // serial clock
    output logic       start_o,    // conversion start line
    output logic       sdi_o       // serial input
);
    logic last_q;
    logic pin_lvl;

    // released pin shows the inverse of its last driven level
    always @(sdo_i or sdo_oe_i) begin
        if (sdo_oe_i) begin
            last_q = sdo_i;
        end
    end
    assign pin_lvl = sdo_oe_i ? sdo_i : ~last_q;

    initial begin
        last_q  = 1'b0;
        sclk_o  = 1'b1;
        start_o = 1'b0;
        sdi_o   = 1'b1;
    end

    // ****************************************************************
    // conversion start, mode 0 three-wire, 1 four-wire, 2 daisy
    // ****************************************************************
    task automatic conv(input int mode);
        @(negedge core_clk_i);
        if (start_o) begin
            start_o = 1'b0;
            repeat (4) @(negedge core_clk_i);
        end
        sdi_o = (mode != 2);
        repeat (3) @(negedge core_clk_i);
        start_o = 1'b1;
        repeat (5) @(negedge core_clk_i);
    endtask : conv

    // ****************************************************************
    // one readout frame of nbits serial clocks
    // ****************************************************************
    task automatic frame(input int mode, input int nbits,
                         input logic [15:0] ups, output logic [31:0] got,
                         output logic ok);
        int k;
        got = 32'h0000_0000;
        k   = 0;
        @(negedge core_clk_i);
        if (mode == 1) begin
            sdi_o = 1'b0;
        end else begin
            start_o = 1'b0;
        end
        while (sdo_oe_i !== 1'b1 && k < 20) begin
            @(negedge core_clk_i);
            k++;
        end
        ok = (sdo_oe_i === 1'b1);
        #7;
        for (k = 0; k < nbits; k++) begin
            if (mode == 2) begin
                sdi_o = ups[15 - (k % 16)];
            end
            #16;
            got[31 - k] = pin_lvl;
            sclk_o = 1'b0;
            #16;
            sclk_o = 1'b1;
        end
    endtask : frame

    // four-wire chip select released
    task automatic cs_off();
        @(negedge core_clk_i);
        sdi_o = 1'b1;
        repeat (5) @(negedge core_clk_i);
    endtask : cs_off
endmodule : host_model

//--- testbench/tb_adc_serial_readout.sv
/*
 * Testbench of the converter serial readout: fills the sample FIFO until
 * it refuses, then drains it through frames in all three arrangements.
 * Assumes host_model as the far side.
 */
`timescale 1ns/1ps
module tb_adc_serial_readout;
    logic        core_clk;
    logic        rst_b;
    logic        sclk;
    logic        start;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic [15:0] sdata;
    logic        svalid;
    logic        sready;
    logic        cstart;
    int          error_cnt;
    int          compares;
    int          pulses;
    logic [15:0] exp_q[$];

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    adc_serial_readout i_dut (
        .core_clk_i              (core_clk),
        .rst_b_i                 (rst_b),
        .serial_clk_i            (sclk),
        .conversion_start_line_i (start),
        .serial_in_i             (sdi),
        .serial_out_o            (sdo),
        .serial_out_oe_o         (sdo_oe),
        .sample_data_i           (sdata),
        .sample_valid_i          (svalid),
        .sample_ready_o          (sready),
        .conv_start_o            (cstart)
    );

    host_model i_host (
        .core_clk_i (core_clk),
        .sdo_i      (sdo),
        .sdo_oe_i   (sdo_oe),
        .sclk_o     (sclk),
        .start_o    (start),
        .sdi_o      (sdi)
    );

    always @(posedge core_clk) begin
        if (cstart === 1'b1) begin
            pulses++;
        end
    end

    // ****************************************************************
    // compare, expectation and closing
    // ****************************************************************
    task automatic chk_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string what, input logic [31:0] e,
                           input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk_val

    // stream seen by the host, top nbits only
    function automatic logic [31:0] exp_frame(input int mode, input int nb,
                                              input logic [15:0] w,
                                              input logic [15:0] u);
        logic [31:0] v;
        v = (mode == 2) ? {w, u} : {w, 16'h0000};
        return v & ~(32'hFFFF_FFFF >> nb);
    endfunction : exp_frame

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int          n;
        int          mode;
        int          nb;
        logic [15:0] w;
        logic [15:0] u;
        logic [31:0] got;
        logic        ok;
        error_cnt = 0;
        compares  = 0;
        pulses    = 0;
        rst_b     = 1'b0;
        svalid    = 1'b0;
        sdata     = 16'h0000;
        void'($urandom(32'h74EF));
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        n = 0;
        while (sready === 1'b1 && n < 40) begin
            w = (n == 0) ? 16'h8001 : (n == 1) ? 16'hFFFF : 16'($urandom);
            sdata  = w;
            svalid = 1'b1;
            exp_q.push_back(w);
            @(negedge core_clk);
            n++;
        end
        sdata = 16'h5A5A;
        @(negedge core_clk);
        chk_val("fill_count", 32'h21, 32'(n));
        chk_bit("ready_full", 1'b0, sready);
        svalid = 1'b0;
        $display("test fifo fill done");
        for (int i = 0; i < 33; i++) begin
            mode = (i < 5) ? i % 3 : $urandom_range(2);
            nb   = (mode == 2) ? 32 :
                   (i == 3 || i == 4 || $urandom_range(3) == 0) ? 8 : 16;
            u    = 16'($urandom);
            i_host.conv(mode);
            chk_bit("oe_after_start", 1'b0, sdo_oe);
            repeat (adc_readout_pkg::CONV_CYC + 10) @(negedge core_clk);
            i_host.frame(mode, nb, u, got, ok);
            chk_bit("oe_rise", 1'b1, ok);
            if (!ok) begin
                break;
            end
            w = exp_q.pop_front();
            chk_val("frame", exp_frame(mode, nb, w, u), got);
            if (mode != 2 && nb == 16) begin
                chk_bit("oe_last_edge", 1'b0, sdo_oe);
            end
            if (mode == 1) begin
                i_host.cs_off();
                chk_bit("oe_cs_high", 1'b0, sdo_oe);
            end
            $display("test frame %0d mode %0d bits %0d done", i, mode, nb);
        end
        chk_bit("ready_drained", 1'b1, sready);
        // mid-run reset with the start line high: no false conversion
        @(negedge core_clk);
        i_host.start_o = 1'b1;
        rst_b          = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge core_clk);
        chk_bit("oe_after_reset", 1'b0, sdo_oe);
        chk_val("start_pulses", 32'h21, 32'(pulses));
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : tb_adc_serial_readout
